// ---- verilog/lrd_pkg.sv ----
`default_nettype none
package lrd_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] LRD_DESC_ADDR = 12'h098;
  localparam logic [31:0] LRD_DESC_RESET = 32'h4000_0000;
  // Bits 15:8 and 25 are unused: they are not stored and read as zero
  localparam logic [31:0] LRD_DESC_MASK = 32'hfdff_00ff;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int LRD_S0_WIDTH_LSB = 0;
  localparam int LRD_S0_WAIT_LSB = 2;
  localparam int LRD_S0_READY_BIT = 6;
  localparam int LRD_S0_BURST_TERMINATE_INPUT_BIT = 7;
  localparam int LRD_ROM_WIDTH_LSB = 16;
  localparam int LRD_ROM_WAIT_LSB = 18;
  localparam int LRD_ROM_READY_BIT = 22;
  localparam int LRD_ROM_BURST_TERMINATE_INPUT_BIT = 23;
  localparam int LRD_S0_BURST_BIT = 24;
  localparam int LRD_ROM_BURST_BIT = 26;
  localparam int LRD_WMODE_BIT = 27;
  localparam int LRD_RETRY_LSB = 28;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int LRD_RETRY_UNIT_CLOCKS = 8;
  localparam int LRD_RETRY_UNIT_SHIFT = 3;
  localparam int LRD_COUNT_W = 7;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    lrd_w8,
    lrd_w16,
    lrd_w32
  } lrd_width_type;

  typedef enum logic [1:0] {
    lrd_idle,
    lrd_pend,
    lrd_xfer,
    lrd_retry
  } lrd_state_type;
endpackage
`default_nettype wire

// ---- verilog/lrd_local_region_descriptor.sv ----
// The address map and register access over APB were left to the implementer.
`default_nettype none
// What this block does
// - Space 0 width field 00/01/1x gives 8/16/32-bit local accesses
// - Space 0 honours local ready only when its enable bit is set
// - Space 0 honours burst terminate only when its enable bit is set
// - ROM space uses the same width encoding as space 0
// - ROM space honours local ready only when its enable bit is set
// - ROM space honours burst terminate only when its enable bit is set
// - Space 0 bursts only when its burst enable bit is set
// - ROM space bursts only when its burst enable bit is set
// - Write mode 0 disconnects the write once the write FIFO is full
// - Write mode 1 holds TRDY off while the write FIFO is full
// - Retry delay is field times eight clocks from access receipt
// - Retry timer covers writes only when write mode bit 27 is set
// - Reset loads four into the retry delay field, 32 clocks
// - Reset clears the write mode bit so a full FIFO disconnects
module lrd_local_region_descriptor
  import lrd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic acc_valid,
  input wire logic acc_rom,
  input wire logic acc_write,
  input wire logic acc_xfer,
  input wire logic wfifo_full,
  output logic tgt_trdy_hold,
  output logic tgt_disconnect,
  output logic tgt_retry,
  input wire logic local_ready,
  input wire logic burst_terminate_input,
  output lrd_width_type loc_width,
  output logic [3:0] loc_wait,
  output logic loc_burst,
  output logic loc_ready,
  output logic loc_burst_terminate_input
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic lrd_width_type width_decode(input logic [1:0] code);
    case (code)
      2'h0: width_decode = lrd_w8;
      2'h1: width_decode = lrd_w16;
      default: width_decode = lrd_w32;
    endcase
  endfunction

  function automatic logic [LRD_COUNT_W-1:0] retry_limit(input logic [3:0] field);
    retry_limit = LRD_COUNT_W'(field) << LRD_RETRY_UNIT_SHIFT;
  endfunction

  logic [31:0] desc;
  lrd_state_type state;
  logic [LRD_COUNT_W-1:0] cnt;
  logic rom_q;
  logic write_q;
  logic ready_meta;
  logic ready_sync;
  logic burst_terminate_input_meta;
  logic burst_terminate_input_sync;
  logic wmode;
  logic [3:0] retry_field;
  logic timer_on;
  logic active;
  logic hit;

  assign wmode = desc[LRD_WMODE_BIT];
  assign retry_field = desc[LRD_RETRY_LSB +: 4];
  assign active = (state == lrd_pend) || (state == lrd_xfer);
  assign hit = (paddr == LRD_DESC_ADDR);
  // Writes only run the timer in wait-state mode
  assign timer_on = (retry_field != 4'h0) && (!write_q || wmode);

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // Zero-wait slave: read data is caught in the setup cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      desc <= LRD_DESC_RESET;
    end else if (psel && penable && pwrite && hit) begin
      for (int i = 0; i < 4; i++) begin
        if (pstrb[i]) begin
          desc[i*8 +: 8] <= pwdata[i*8 +: 8] & LRD_DESC_MASK[i*8 +: 8];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= (hit && !pwrite) ? desc : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ready_meta <= 1'b0;
      ready_sync <= 1'b0;
      burst_terminate_input_meta <= 1'b0;
      burst_terminate_input_sync <= 1'b0;
    end else begin
      ready_meta <= local_ready;
      ready_sync <= ready_meta;
      burst_terminate_input_meta <= burst_terminate_input;
      burst_terminate_input_sync <= burst_terminate_input_meta;
    end
  end

  // ----------------------------------------------------------------
  // Per-space local bus settings
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      loc_width <= lrd_w8;
      loc_wait <= 4'h0;
      loc_burst <= 1'b0;
      loc_ready <= 1'b0;
      loc_burst_terminate_input <= 1'b0;
    end else if (rom_q) begin
      loc_width <= width_decode(desc[LRD_ROM_WIDTH_LSB +: 2]);
      loc_wait <= desc[LRD_ROM_WAIT_LSB +: 4];
      loc_burst <= desc[LRD_ROM_BURST_BIT];
      loc_ready <= desc[LRD_ROM_READY_BIT] && ready_sync;
      loc_burst_terminate_input <= desc[LRD_ROM_BURST_TERMINATE_INPUT_BIT] && burst_terminate_input_sync;
    end else begin
      loc_width <= width_decode(desc[LRD_S0_WIDTH_LSB +: 2]);
      loc_wait <= desc[LRD_S0_WAIT_LSB +: 4];
      loc_burst <= desc[LRD_S0_BURST_BIT];
      loc_ready <= desc[LRD_S0_READY_BIT] && ready_sync;
      loc_burst_terminate_input <= desc[LRD_S0_BURST_TERMINATE_INPUT_BIT] && burst_terminate_input_sync;
    end
  end

  // ----------------------------------------------------------------
  // Target access tracking and retry timer
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rom_q <= 1'b0;
      write_q <= 1'b0;
    end else if (state == lrd_idle && acc_valid) begin
      rom_q <= acc_rom;
      write_q <= acc_write;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state <= lrd_idle;
    end else begin
      case (state)
        lrd_idle: begin
          if (acc_valid) begin
            state <= lrd_pend;
          end
        end
        lrd_pend: begin
          if (!acc_valid) begin
            state <= lrd_idle;
          end else if (acc_xfer) begin
            state <= lrd_xfer;
          end else if (timer_on && cnt == retry_limit(retry_field) - 1'b1) begin
            state <= lrd_retry;
          end
        end
        lrd_xfer, lrd_retry: begin
          if (!acc_valid) begin
            state <= lrd_idle;
          end
        end
        default: state <= lrd_idle;
      endcase
    end
  end

  // Counter only runs before the first data phase; it restarts per access
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt <= '0;
    end else if (state == lrd_pend) begin
      cnt <= cnt + 1'b1;
    end else begin
      cnt <= '0;
    end
  end

  assign tgt_retry = (state == lrd_retry);
  // Full FIFO: mode 1 stretches with wait states, mode 0 disconnects
  assign tgt_trdy_hold = active && write_q && wmode && wfifo_full;
  assign tgt_disconnect = active && write_q && !wmode && wfifo_full;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [LRD_COUNT_W:0] age;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      age <= '0;
    end else if (state == lrd_idle) begin
      age <= '0;
    end else if (state == lrd_pend) begin
      age <= age + 1'b1;
    end
  end

  sequence s_receipt;
    state == lrd_idle && acc_valid;
  endsequence

  sequence s_retry_rise;
    $rose(tgt_retry);
  endsequence

  chk_s0_width: assert property (
    @(posedge clk) disable iff (!rst_b)
    !rom_q |=> loc_width == width_decode($past(desc[1:0])))
    else $error("space 0 width does not follow its field");

  chk_rom_width: assert property (
    @(posedge clk) disable iff (!rst_b)
    rom_q |=> loc_width == width_decode($past(desc[17:16])))
    else $error("ROM width does not follow its field");

  chk_s0_ready_gate: assert property (
    @(posedge clk) disable iff (!rst_b)
    !rom_q |=> loc_ready == ($past(desc[6]) && $past(ready_sync)))
    else $error("space 0 ready gating wrong");

  chk_s0_burst_terminate_input_gate: assert property (
    @(posedge clk) disable iff (!rst_b)
    !rom_q |=> loc_burst_terminate_input == ($past(desc[7]) && $past(burst_terminate_input_sync)))
    else $error("space 0 burst terminate gating wrong");

  chk_rom_ready_gate: assert property (
    @(posedge clk) disable iff (!rst_b)
    rom_q |=> loc_ready == ($past(desc[22]) && $past(ready_sync)))
    else $error("ROM ready gating wrong");

  chk_rom_burst_terminate_input_gate: assert property (
    @(posedge clk) disable iff (!rst_b)
    rom_q |=> loc_burst_terminate_input == ($past(desc[23]) && $past(burst_terminate_input_sync)))
    else $error("ROM burst terminate gating wrong");

  chk_burst_select: assert property (
    @(posedge clk) disable iff (!rst_b)
    1'b1 |=> loc_burst == ($past(rom_q) ? $past(desc[26]) : $past(desc[24])))
    else $error("burst enable taken from wrong space");

  chk_full_disconnect: assert property (
    @(posedge clk) disable iff (!rst_b)
    (active && write_q && !desc[27] && wfifo_full) |-> tgt_disconnect && !tgt_trdy_hold)
    else $error("mode 0 full FIFO did not disconnect");

  chk_full_wait: assert property (
    @(posedge clk) disable iff (!rst_b)
    (active && write_q && desc[27] && wfifo_full) |-> tgt_trdy_hold && !tgt_disconnect)
    else $error("mode 1 full FIFO did not hold TRDY");

  chk_retry_delay: assert property (
    @(posedge clk) disable iff (!rst_b)
    s_retry_rise |-> age == {1'b0, retry_limit($past(desc[31:28]))})
    else $error("retry came at the wrong clock");

  chk_receipt_start: assert property (
    @(posedge clk) disable iff (!rst_b)
    s_receipt ##1 !acc_xfer |-> !tgt_retry ##1 !tgt_retry)
    else $error("retry too soon after receipt");

  chk_write_no_timer: assert property (
    @(posedge clk) disable iff (!rst_b)
    (state == lrd_pend && write_q && !desc[27]) |=> !tgt_retry)
    else $error("retry timer ran on a mode 0 write");

  chk_no_retry_after_data: assert property (
    @(posedge clk) disable iff (!rst_b)
    (state == lrd_pend && acc_xfer) |=> !tgt_retry [*2])
    else $error("retry after a completed data phase");

  chk_reset_value: assert property (
    @(posedge clk) disable iff (!rst_b)
    !$past(rst_b) |-> desc[31:28] == 4'h4 && !desc[27])
    else $error("descriptor reset value wrong");

  chk_retry_stands: assert property (
    @(posedge clk) disable iff (!rst_b)
    (tgt_retry && acc_valid) |=> tgt_retry)
    else $error("retry dropped while the access was still held");

  chk_retry_release: assert property (
    @(posedge clk) disable iff (!rst_b)
    (tgt_retry && !acc_valid) |=> !tgt_retry)
    else $error("retry outlived the access");

  chk_zero_delay_off: assert property (
    @(posedge clk) disable iff (!rst_b)
    (state == lrd_pend && desc[LRD_RETRY_LSB +: 4] == 4'h0) |=> !tgt_retry)
    else $error("retry with a zero delay field");

  chk_read_no_full: assert property (
    @(posedge clk) disable iff (!rst_b)
    !write_q |-> !tgt_trdy_hold && !tgt_disconnect)
    else $error("full FIFO response on a read");

  chk_idle_quiet: assert property (
    @(posedge clk) disable iff (!rst_b)
    state == lrd_idle |-> !tgt_retry && !tgt_trdy_hold && !tgt_disconnect)
    else $error("target response with no access in progress");

  chk_unused_zero: assert property (
    @(posedge clk) disable iff (!rst_b)
    (desc & ~LRD_DESC_MASK) == 32'h0000_0000)
    else $error("unused descriptor bits were stored");

  chk_mode_write: assert property (
    @(posedge clk) disable iff (!rst_b)
    (psel && penable && pwrite && hit && pstrb[3]) |=> wmode == $past(pwdata[LRD_WMODE_BIT]))
    else $error("write mode bit did not take the written value");

endmodule
`default_nettype wire

// ---- testbench/lrd_pci_master.sv ----
`default_nettype none
module lrd_pci_master (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic rom,
  input wire logic wr,
  input wire logic xfer,
  input wire logic tgt_retry,
  output logic acc_valid,
  output logic acc_rom,
  output logic acc_write,
  output logic acc_xfer,
  output logic done,
  output logic [7:0] retry_at
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] cnt;
  // ----------------------------------------
  // Target access sequencing
  // ----------------------------------------
  always_ff @(posedge clk) begin
    done <= 1'b0;
    acc_xfer <= 1'b0;
    if (!rst_b) begin
      acc_valid <= 1'b0;
      acc_rom <= 1'b0;
      acc_write <= 1'b0;
      cnt <= 8'h00;
      retry_at <= 8'h00;
    end else if (!acc_valid) begin
      // Idle lines toggle so a stale value never looks live
      acc_rom <= ~acc_rom;
      acc_write <= ~acc_write;
      if (start) begin
        acc_valid <= 1'b1;
        acc_rom <= rom;
        acc_write <= wr;
        cnt <= 8'h00;
        retry_at <= 8'h00;
      end
    end else begin
      cnt <= cnt + 8'h01;
      acc_xfer <= xfer && cnt == 8'h01;
      if (tgt_retry) begin
        // A retried access is dropped, to be reissued later
        retry_at <= cnt;
        acc_valid <= 1'b0;
        done <= 1'b1;
      end else if (cnt == 8'h64) begin
        acc_valid <= 1'b0;
        done <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- testbench/lrd_local_region_descriptor_tb.sv ----
`default_nettype none
module lrd_local_region_descriptor_tb
  import lrd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, desc, lfsr, rd, d;
  logic [3:0] pstrb, loc_wait;
  logic start, rom, wr, xfer, acc_valid, acc_rom, acc_write, acc_xfer, done, tgt_retry;
  logic wfifo_full, tgt_trdy_hold, tgt_disconnect, local_ready, burst_terminate_input;
  logic loc_burst, loc_ready, loc_burst_terminate_input;
  logic [7:0] retry_at;
  lrd_width_type loc_width;
  int mismatches, n_checks;
  int cyc = 0;

  lrd_local_region_descriptor i_lrd_local_region_descriptor (.clk(clk), .rst_b(rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .acc_valid(acc_valid), .acc_rom(acc_rom), .acc_write(acc_write), .acc_xfer(acc_xfer),
    .wfifo_full(wfifo_full), .tgt_trdy_hold(tgt_trdy_hold), .tgt_disconnect(tgt_disconnect),
    .tgt_retry(tgt_retry), .local_ready(local_ready),
    .burst_terminate_input(burst_terminate_input), .loc_width(loc_width),
    .loc_wait(loc_wait), .loc_burst(loc_burst), .loc_ready(loc_ready), .loc_burst_terminate_input(loc_burst_terminate_input));

  lrd_pci_master i_lrd_pci_master (.clk(clk), .rst_b(rst_b), .start(start), .rom(rom),
    .wr(wr), .xfer(xfer), .tgt_retry(tgt_retry), .acc_valid(acc_valid), .acc_rom(acc_rom),
    .acc_write(acc_write), .acc_xfer(acc_xfer), .done(done), .retry_at(retry_at));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    chk(got, exp);
  endtask

  task automatic chk_err(input logic [31:0] got, input logic [31:0] exp);
    chk(got, exp);
  endtask

  task automatic chk_loc(input logic [31:0] got, input logic [31:0] exp);
    chk(got, exp);
  endtask

  task automatic chk_tgt(input logic [31:0] got, input logic [31:0] exp);
    chk(got, exp);
  endtask

  // ----------------------------------------
  // Register access, checked against the model
  // ----------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     input logic [3:0] s);
    int n;
    logic [31:0] m;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
    if (n >= 20)
      mismatches++;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & LRD_DESC_MASK;
    chk_err({31'h0, err}, {31'h0, a != LRD_DESC_ADDR});
    if (w && a == LRD_DESC_ADDR)
      desc = (desc & ~m) | (wd & m);
    if (!w)
      chk_reg(rd, a == LRD_DESC_ADDR ? desc : 32'h0);
  endtask

  // ----------------------------------------
  // One target access through the host model
  // ----------------------------------------
  task automatic acc(input logic r, input logic w, input logic x);
    int n;
    int f;
    int exp_at;
    logic [31:0] sp;
    logic [2:0] e;
    f = desc[31:28];
    sp = r ? desc >> 16 : desc;
    e = {desc[r ? 26 : 24], sp[6] & local_ready, sp[7] & burst_terminate_input};
    start <= 1'b1;
    rom <= r;
    wr <= w;
    xfer <= x;
    @(posedge clk);
    start <= 1'b0;
    repeat (3) @(posedge clk);
    chk_loc(32'(loc_width), sp[1:0] == 2'b00 ? 0 : sp[1:0] == 2'b01 ? 1 : 2);
    chk_loc({28'h0, loc_wait}, {28'h0, sp[5:2]});
    chk_loc({31'h0, loc_burst}, {31'h0, e[2]});
    chk_loc({30'h0, loc_ready, loc_burst_terminate_input}, {30'h0, e[1:0]});
    e = {1'b0, w & wfifo_full & ~desc[27], w & wfifo_full & desc[27]};
    chk_tgt({30'h0, tgt_disconnect, tgt_trdy_hold}, {29'h0, e});
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (done !== 1'b1 && n < 200);
    if (n >= 200)
      mismatches++;
    // The host model sees the retry one edge after it is raised
    exp_at = (f != 0 && !x && (!w || desc[LRD_WMODE_BIT])) ? f * LRD_RETRY_UNIT_CLOCKS + 1 : 0;
    chk_tgt({24'h0, retry_at}, exp_at);
    @(posedge clk);
  endtask

  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    {start, rom, wr, xfer, wfifo_full, local_ready, burst_terminate_input} = 7'h00;
    mismatches = 0;
    n_checks = 0;
    lfsr = 32'he2a10d57;
    desc = 32'h4000_0000;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    apb(1'b0, LRD_DESC_ADDR, 32'h0, 4'hf);
    acc(1'b0, 1'b0, 1'b0);
    apb(1'b1, 12'h09c, 32'hffff_ffff, 4'hf);
    apb(1'b0, 12'h09c, 32'h0, 4'hf);
    apb(1'b0, LRD_DESC_ADDR, 32'h0, 4'hf);
    for (int i = 0; i < 24; i++) begin
      lfsr = lfsr_next(lfsr);
      d = lfsr;
      d[1:0] = 2'(i >> 2);
      d[17:16] = 2'(i >> 2);
      d[5:2] = 4'h0;
      d[21:18] = 4'h0;
      d[31:28] = 4'(i % 7);
      {wfifo_full, local_ready, burst_terminate_input} <= lfsr[14:12];
      apb(1'b1, LRD_DESC_ADDR, d, i < 16 ? 4'hf : lfsr[3:0]);
      apb(1'b0, LRD_DESC_ADDR, 32'h0, 4'hf);
      acc(i[0], i[1], i % 3 == 0);
    end
    wrap_up;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      wrap_up;
    end
  end
endmodule
`default_nettype wire
